//--- hw/ch3_io_pkg.sv
// What this block does
// [R01] a compare code with a low action drives the pin low at each match, starting low for 0001 and high for 0101.
// [R02] codes 0010 and 0110 drive the pin high at each match, starting low and high respectively.
// [R03] codes 0011 and 0111 invert the pin at each match, starting low and high respectively.
// [R04] code 1000 loads the counter into the general register on each rising pin edge.
// [R05] code 1001 loads the counter into the general register on each falling pin edge.
// [R06] codes 101x load the counter into the general register on both pin edges.
// [R07] codes 11xx load the counter into the general register whenever channel 4 counts up or down.
// [R08] when the channel 4 prescale field is 000 the channel 4 count capture never happens.
// [R09] the channel 4 count source serves general register B exactly as it serves register A.
// [R10] codes 0000 and 0100 keep the pin undriven but still compare; bits 7..4 are B's code, 3..0 A's.
package ch3_io_pkg;

  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_PIN_FUNC   = 16'hFE82;
  localparam logic [15:0] IDX_GR_A       = 16'hFE88;
  localparam logic [15:0] IDX_GR_B       = 16'hFE8A;
  localparam logic [15:0] IDX_STATUS     = 16'hFE90;
  localparam logic [15:0] IDX_MASK       = 16'hFE91;
  localparam logic [15:0] IDX_PIN_STATE  = 16'hFE92;
  localparam int          ADDR_W         = 18;

  // field positions and reset values
  localparam int          CODE_A_LSB     = 0;
  localparam int          CODE_B_LSB     = 4;
  localparam logic [7:0]  PIN_FUNC_RST   = 8'h00;
  localparam logic [15:0] GR_RST         = 16'hFFFF;
  localparam logic [3:0]  EVT_RST        = 4'h0;
  localparam int          EVT_MATCH_A    = 0;
  localparam int          EVT_MATCH_B    = 1;
  localparam int          EVT_CAPT_A     = 2;
  localparam int          EVT_CAPT_B     = 3;
  localparam logic [2:0]  PRESCALE_UNDIV = 3'h0;

  // compare actions held in the low two code bits
  localparam logic [1:0]  ACT_NONE       = 2'h0;
  localparam logic [1:0]  ACT_LOW        = 2'h1;
  localparam logic [1:0]  ACT_HIGH       = 2'h2;
  localparam logic [1:0]  ACT_TOGGLE     = 2'h3;

  typedef enum logic [1:0] {
    APB_IDLE   = 2'b00,
    APB_ANSWER = 2'b01
  } apb_phase_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } apb_req_t;

  typedef struct packed {
    logic rise;
    logic fall;
    logic level;
  } pin_edge_t;

  // code in compare mode (top bit clear)
  function automatic logic is_compare(input logic [3:0] code);
    return ~code[3];
  endfunction : is_compare

  // capture decision for one general register
  function automatic logic capture_hit(input logic [3:0] code,
                                       input pin_edge_t  edges,
                                       input logic       ch4_event);
    logic hit;
    hit = 1'b0;
    case (code[3:2])
      2'b10:   hit = code[1] ? (edges.rise | edges.fall)                // [R06]
                   : (code[0] ? edges.fall : edges.rise);               // [R04] [R05]
      2'b11:   hit = ch4_event;                                         // [R07]
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction : capture_hit

endpackage : ch3_io_pkg

//--- hw/pin_edge_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_edge_sync (
  input  wire logic                  clk_in,
  input  wire logic                  rst_n_in,
  input  wire logic                  pin_in,
  output ch3_io_pkg::pin_edge_t      edges_out
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } sync_state_t;

  sync_state_t state_ff;
  sync_state_t nxt_state;

  // meta is read only by sync; edges come from sync against last
  always_comb begin
    nxt_state      = state_ff;
    nxt_state.meta = pin_in;
    nxt_state.sync = state_ff.meta;
    nxt_state.last = state_ff.sync;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // one-cycle edge pulses, level of the synchronised pin
  assign edges_out.rise  = state_ff.sync & ~state_ff.last;
  assign edges_out.fall  = ~state_ff.sync & state_ff.last;
  assign edges_out.level = state_ff.sync;

endmodule : pin_edge_sync
`default_nettype wire

//--- hw/compare_pin_driver.sv
`timescale 1ns/1ps
`default_nettype none
module compare_pin_driver (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [3:0] code_in,
  input  wire logic       load_in,
  input  wire logic [3:0] load_code_in,
  input  wire logic       match_in,
  output logic            level_out,
  output logic            oe_out
);

  typedef struct packed {
    logic level;
    logic oe;
  } drv_state_t;

  drv_state_t state_ff;
  drv_state_t nxt_state;

  // a new compare code with a pin action sets the initial level; a match then applies the action
  always_comb begin
    nxt_state    = state_ff;
    nxt_state.oe = ch3_io_pkg::is_compare(code_in) &&
                   (code_in[1:0] != ch3_io_pkg::ACT_NONE);          // [R10]
    if (load_in && ch3_io_pkg::is_compare(load_code_in) &&
        (load_code_in[1:0] != ch3_io_pkg::ACT_NONE)) begin
      nxt_state.level = load_code_in[2];                            // [R01] [R02] [R03]
      nxt_state.oe    = 1'b1;
    end else if (match_in && ch3_io_pkg::is_compare(code_in)) begin
      case (code_in[1:0])
        ch3_io_pkg::ACT_LOW:    nxt_state.level = 1'b0;             // [R01]
        ch3_io_pkg::ACT_HIGH:   nxt_state.level = 1'b1;             // [R02]
        ch3_io_pkg::ACT_TOGGLE: nxt_state.level = ~state_ff.level;  // [R03]
        default:                nxt_state.level = state_ff.level;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign level_out = state_ff.level;
  assign oe_out    = state_ff.oe;

endmodule : compare_pin_driver
`default_nettype wire

//--- hw/timer_ch3_io_control.sv
`timescale 1ns/1ps
`default_nettype none
module timer_ch3_io_control (
  input  wire logic                          CLK_IN,
  input  wire logic                          RESET_N_IN,
  // apb slave
  input  wire logic                          PSEL_IN,
  input  wire logic                          PENABLE_IN,
  input  wire logic                          PWRITE_IN,
  input  wire logic [ch3_io_pkg::ADDR_W-1:0] PADDR_IN,
  input  wire logic [31:0]                   PWDATA_IN,
  output logic                               PREADY_OUT,
  output logic                               PSLVERR_OUT,
  output logic      [31:0]                   PRDATA_OUT,
  // counters and channel 4 controls, same clock
  input  wire logic [15:0]                   CH3_COUNTER_IN,
  input  wire logic                          CH4_COUNT_EVENT_IN,
  input  wire logic [2:0]                    CH4_PRESCALE_IN,
  // two-way timer pins
  input  wire logic                          CH3_PIN_A_IN,
  output logic                               CH3_PIN_A_OUT,
  output logic                               CH3_PIN_A_OE_OUT,
  input  wire logic                          CH3_PIN_B_IN,
  output logic                               CH3_PIN_B_OUT,
  output logic                               CH3_PIN_B_OE_OUT,
  // interrupt
  output logic                               IRQ_OUT
);

  typedef struct packed {
    ch3_io_pkg::apb_phase_t phase;
    logic                   pready;
    logic                   pslverr;
    logic [31:0]            prdata;
    logic [7:0]             pin_func;
    logic [15:0]            gr_a;
    logic [15:0]            gr_b;
    logic [3:0]             status;
    logic [3:0]             mask;
    logic                   irq;
    logic                   match_a_seen;
    logic                   match_b_seen;
  } ctrl_state_t;

  ctrl_state_t          state_ff;
  ctrl_state_t          nxt_state;
  ch3_io_pkg::apb_req_t req;
  ch3_io_pkg::pin_edge_t edges_a;
  ch3_io_pkg::pin_edge_t edges_b;
  logic [1:0]           rst_sync_ff;
  logic                 rst_n;
  logic [3:0]           code_a;
  logic [3:0]           code_b;
  logic                 access;
  logic                 wr_pin_func;
  logic [3:0]           new_code_a;
  logic [3:0]           new_code_b;
  logic                 eq_a;
  logic                 eq_b;
  logic                 match_a;
  logic                 match_b;
  logic                 ch4_event;
  logic                 capt_a;
  logic                 capt_b;
  logic                 pin_a_level;
  logic                 pin_b_level;
  logic                 pin_a_oe;
  logic                 pin_b_oe;

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_ff[1];

  // bundle the bus request
  assign req.psel    = PSEL_IN;
  assign req.penable = PENABLE_IN;
  assign req.pwrite  = PWRITE_IN;
  assign req.paddr   = PADDR_IN;
  assign req.pwdata  = PWDATA_IN;

  // pins cross into the clock domain before anything reads them
  pin_edge_sync u_sync_a (
    .clk_in    (CLK_IN),
    .rst_n_in  (rst_n),
    .pin_in    (CH3_PIN_A_IN),
    .edges_out (edges_a)
  );

  pin_edge_sync u_sync_b (
    .clk_in    (CLK_IN),
    .rst_n_in  (rst_n),
    .pin_in    (CH3_PIN_B_IN),
    .edges_out (edges_b)
  );

  // code fields of the pin function register
  assign code_a     = state_ff.pin_func[ch3_io_pkg::CODE_A_LSB +: 4];   // [R10]
  assign code_b     = state_ff.pin_func[ch3_io_pkg::CODE_B_LSB +: 4];   // [R10]
  assign new_code_a = req.pwdata[ch3_io_pkg::CODE_A_LSB +: 4];
  assign new_code_b = req.pwdata[ch3_io_pkg::CODE_B_LSB +: 4];

  // an access is taken once, in the cycle before pready rises
  assign access      = req.psel && req.penable &&
                       (state_ff.phase == ch3_io_pkg::APB_IDLE);
  assign wr_pin_func = access && req.pwrite &&
                       (req.paddr == {ch3_io_pkg::IDX_PIN_FUNC, 2'b00});

  // compare runs in every compare code, pin drive or not; one pulse
  // per arrival at equality so a stopped counter does not re-toggle
  assign eq_a    = ch3_io_pkg::is_compare(code_a) && (CH3_COUNTER_IN == state_ff.gr_a); // [R10]
  assign eq_b    = ch3_io_pkg::is_compare(code_b) && (CH3_COUNTER_IN == state_ff.gr_b); // [R10]
  assign match_a = eq_a && !state_ff.match_a_seen;
  assign match_b = eq_b && !state_ff.match_b_seen;

  // channel 4 count source is void with the undivided clock
  assign ch4_event = CH4_COUNT_EVENT_IN &&
                     (CH4_PRESCALE_IN != ch3_io_pkg::PRESCALE_UNDIV);     // [R08]

  // capture decisions; the same source feeds both registers
  assign capt_a = ch3_io_pkg::capture_hit(code_a, edges_a, ch4_event);   // [R04] [R05] [R06] [R07]
  assign capt_b = ch3_io_pkg::capture_hit(code_b, edges_b, ch4_event);   // [R09]

  // pin level and enable for each compare output
  compare_pin_driver u_drv_a (
    .clk_in       (CLK_IN),
    .rst_n_in     (rst_n),
    .code_in      (code_a),
    .load_in      (wr_pin_func),
    .load_code_in (new_code_a),
    .match_in     (match_a),
    .level_out    (pin_a_level),
    .oe_out       (pin_a_oe)
  );

  compare_pin_driver u_drv_b (
    .clk_in       (CLK_IN),
    .rst_n_in     (rst_n),
    .code_in      (code_b),
    .load_in      (wr_pin_func),
    .load_code_in (new_code_b),
    .match_in     (match_b),
    .level_out    (pin_b_level),
    .oe_out       (pin_b_oe)
  );

  // register read mux
  function automatic logic [31:0] read_word(input logic [ch3_io_pkg::ADDR_W-1:0] addr,
                                            input ctrl_state_t                   st,
                                            input logic [3:0]                    pins);
    logic [31:0] word;
    word = 32'h0000_0000;
    case (addr)
      {ch3_io_pkg::IDX_PIN_FUNC, 2'b00}:  word = {24'h000000, st.pin_func};
      {ch3_io_pkg::IDX_GR_A, 2'b00}:      word = {16'h0000, st.gr_a};
      {ch3_io_pkg::IDX_GR_B, 2'b00}:      word = {16'h0000, st.gr_b};
      {ch3_io_pkg::IDX_STATUS, 2'b00}:    word = {28'h0000000, st.status};
      {ch3_io_pkg::IDX_MASK, 2'b00}:      word = {28'h0000000, st.mask};
      {ch3_io_pkg::IDX_PIN_STATE, 2'b00}: word = {28'h0000000, pins};
      default:                            word = 32'h0000_0000;
    endcase
    return word;
  endfunction : read_word

  // mapped address check, shared by read and write paths
  function automatic logic is_mapped(input logic [ch3_io_pkg::ADDR_W-1:0] addr);
    logic hit;
    hit = 1'b0;
    case (addr)
      {ch3_io_pkg::IDX_PIN_FUNC, 2'b00},
      {ch3_io_pkg::IDX_GR_A, 2'b00},
      {ch3_io_pkg::IDX_GR_B, 2'b00},
      {ch3_io_pkg::IDX_STATUS, 2'b00},
      {ch3_io_pkg::IDX_MASK, 2'b00},
      {ch3_io_pkg::IDX_PIN_STATE, 2'b00}: hit = 1'b1;
      default:                            hit = 1'b0;
    endcase
    return hit;
  endfunction : is_mapped

  // bus slave, registers, capture and event logic
  always_comb begin
    nxt_state              = state_ff;
    nxt_state.pready       = 1'b0;
    nxt_state.pslverr      = 1'b0;
    nxt_state.match_a_seen = eq_a;
    nxt_state.match_b_seen = eq_b;

    // apb: one wait state, answer pulses for a single cycle
    case (state_ff.phase)
      ch3_io_pkg::APB_IDLE: begin
        if (access) begin
          nxt_state.phase   = ch3_io_pkg::APB_ANSWER;
          nxt_state.pready  = 1'b1;
          nxt_state.pslverr = !is_mapped(req.paddr);
          nxt_state.prdata  = req.pwrite ? 32'h0000_0000 :
                              read_word(req.paddr, state_ff,
                                        {pin_b_level, pin_a_level,
                                         edges_b.level, edges_a.level});
        end
      end
      ch3_io_pkg::APB_ANSWER: begin
        nxt_state.phase = ch3_io_pkg::APB_IDLE;
      end
      default: begin
        nxt_state.phase = ch3_io_pkg::APB_IDLE;
      end
    endcase

    // software writes; hardware capture below takes priority
    if (access && req.pwrite) begin
      case (req.paddr)
        {ch3_io_pkg::IDX_PIN_FUNC, 2'b00}: nxt_state.pin_func = req.pwdata[7:0];
        {ch3_io_pkg::IDX_GR_A, 2'b00}:     nxt_state.gr_a     = req.pwdata[15:0];
        {ch3_io_pkg::IDX_GR_B, 2'b00}:     nxt_state.gr_b     = req.pwdata[15:0];
        {ch3_io_pkg::IDX_STATUS, 2'b00}:   nxt_state.status   = state_ff.status & ~req.pwdata[3:0];
        {ch3_io_pkg::IDX_MASK, 2'b00}:     nxt_state.mask     = req.pwdata[3:0];
        default:                           nxt_state.pin_func = state_ff.pin_func;
      endcase
    end

    // capture loads the counter; it beats a same-cycle software write
    if (capt_a) begin
      nxt_state.gr_a = CH3_COUNTER_IN;                        // [R04] [R05] [R06] [R07]
    end
    if (capt_b) begin
      nxt_state.gr_b = CH3_COUNTER_IN;                        // [R09]
    end

    // sticky events; a set wins over a same-cycle clear
    nxt_state.status[ch3_io_pkg::EVT_MATCH_A] = nxt_state.status[ch3_io_pkg::EVT_MATCH_A] | match_a;
    nxt_state.status[ch3_io_pkg::EVT_MATCH_B] = nxt_state.status[ch3_io_pkg::EVT_MATCH_B] | match_b;
    nxt_state.status[ch3_io_pkg::EVT_CAPT_A]  = nxt_state.status[ch3_io_pkg::EVT_CAPT_A]  | capt_a;
    nxt_state.status[ch3_io_pkg::EVT_CAPT_B]  = nxt_state.status[ch3_io_pkg::EVT_CAPT_B]  | capt_b;

    // level interrupt from the next status and mask, registered with them
    nxt_state.irq = |(nxt_state.status & nxt_state.mask);
  end

  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      state_ff.phase        <= ch3_io_pkg::APB_IDLE;
      state_ff.pready       <= 1'b0;
      state_ff.pslverr      <= 1'b0;
      state_ff.prdata       <= 32'h0000_0000;
      state_ff.pin_func     <= ch3_io_pkg::PIN_FUNC_RST;
      state_ff.gr_a         <= ch3_io_pkg::GR_RST;
      state_ff.gr_b         <= ch3_io_pkg::GR_RST;
      state_ff.status       <= ch3_io_pkg::EVT_RST;
      state_ff.mask         <= ch3_io_pkg::EVT_RST;
      state_ff.irq          <= 1'b0;
      state_ff.match_a_seen <= 1'b0;
      state_ff.match_b_seen <= 1'b0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // every output is a flop
  assign PREADY_OUT       = state_ff.pready;
  assign PSLVERR_OUT      = state_ff.pslverr;
  assign PRDATA_OUT       = state_ff.prdata;
  assign IRQ_OUT          = state_ff.irq;
  assign CH3_PIN_A_OUT    = pin_a_level;
  assign CH3_PIN_A_OE_OUT = pin_a_oe;
  assign CH3_PIN_B_OUT    = pin_b_level;
  assign CH3_PIN_B_OE_OUT = pin_b_oe;

endmodule : timer_ch3_io_control
`default_nettype wire

//--- verification/pin_far.sv
`timescale 1ns/1ps
`default_nettype none
// far side of one two-way timer pin
module pin_far (
  input  wire logic dut_lvl_in,
  input  wire logic dut_oe_in,
  input  wire logic far_lvl_in,
  output logic      pin_out
);
  // far end drives only while the block lets go, so no fight on the wire
  assign pin_out = dut_oe_in ? dut_lvl_in : far_lvl_in;
endmodule : pin_far
`default_nettype wire

//--- verification/timer_ch3_io_control_chk.sv
`timescale 1ns/1ps
`default_nettype none
module timer_ch3_io_control_chk (
  input  wire logic                          CLK_IN,
  input  wire logic                          RESET_N_IN,
  input  wire logic                          PSEL_IN,
  input  wire logic                          PENABLE_IN,
  input  wire logic                          PWRITE_IN,
  input  wire logic [ch3_io_pkg::ADDR_W-1:0] PADDR_IN,
  input  wire logic [31:0]                   PWDATA_IN,
  input  wire logic                          PREADY_OUT,
  input  wire logic                          PSLVERR_OUT,
  input  wire logic [31:0]                   PRDATA_OUT,
  input  wire logic [15:0]                   CH3_COUNTER_IN,
  input  wire logic                          CH4_COUNT_EVENT_IN,
  input  wire logic [2:0]                    CH4_PRESCALE_IN,
  input  wire logic                          CH3_PIN_A_IN,
  input  wire logic                          CH3_PIN_A_OUT,
  input  wire logic                          CH3_PIN_A_OE_OUT,
  input  wire logic                          CH3_PIN_B_IN,
  input  wire logic                          CH3_PIN_B_OUT,
  input  wire logic                          CH3_PIN_B_OE_OUT,
  input  wire logic                          IRQ_OUT
);
  localparam logic [17:0] PF_ADDR = {ch3_io_pkg::IDX_PIN_FUNC, 2'b00};
  // pin function write answered in this cycle, taken at the edge that opened it
  logic pf_wr;
  assign pf_wr = PSEL_IN & PENABLE_IN & PWRITE_IN & PREADY_OUT & (PADDR_IN == PF_ADDR);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  // bus answer timing
  AST_READY_TIME: assert property (PSEL_IN && $rose(PENABLE_IN) |=> PREADY_OUT)
    else $error("ready not one cycle after access");
  AST_READY_PULSE: assert property (PREADY_OUT |=> !PREADY_OUT)
    else $error("ready longer than one cycle");
  AST_READY_CAUSE: assert property (PREADY_OUT |-> $past(PSEL_IN && PENABLE_IN))
    else $error("ready without access");
  AST_ERR_READY: assert property (PSLVERR_OUT |-> PREADY_OUT)
    else $error("error outside answer");
  AST_ERR_RDATA: assert property (PREADY_OUT && PSLVERR_OUT && !PWRITE_IN |-> PRDATA_OUT == 32'h0)
    else $error("refused read data not zero");
  AST_RSVD_ZERO: assert property (
    PREADY_OUT && !PWRITE_IN && PADDR_IN == PF_ADDR |-> PRDATA_OUT[31:8] == 24'h0)
    else $error("upper pin function bits not zero");
  // output enable and start level follow the code written
  AST_OE_A: assert property (
    pf_wr |=> CH3_PIN_A_OE_OUT == (!$past(PWDATA_IN[3]) && $past(PWDATA_IN[1:0]) != 2'h0))
    else $error("pin a enable wrong after code write");
  AST_OE_B: assert property (
    pf_wr |=> CH3_PIN_B_OE_OUT == (!$past(PWDATA_IN[7]) && $past(PWDATA_IN[5:4]) != 2'h0))
    else $error("pin b enable wrong after code write");
  AST_INIT_A: assert property (
    pf_wr && !PWDATA_IN[3] && PWDATA_IN[1:0] != 2'h0 |=> CH3_PIN_A_OUT == $past(PWDATA_IN[2]))
    else $error("pin a start level wrong");
  // an action code enables at the answer cycle itself, a silent code drops the enable one cycle later
  AST_OE_CAUSE: assert property ($changed(CH3_PIN_A_OE_OUT) |-> pf_wr || $past(pf_wr))
    else $error("pin a enable moved without code write");
endmodule : timer_ch3_io_control_chk
bind timer_ch3_io_control timer_ch3_io_control_chk chk (.*);
`default_nettype wire

//--- verification/timer_ch3_io_control_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
  $display("ERROR %0t got %0h exp %0h", $time, g, e); end end
module timer_ch3_io_control_test;
  localparam logic [15:0] PF = ch3_io_pkg::IDX_PIN_FUNC;
  localparam logic [15:0] GA = ch3_io_pkg::IDX_GR_A;
  localparam logic [15:0] GB = ch3_io_pkg::IDX_GR_B;
  localparam logic [15:0] ST = ch3_io_pkg::IDX_STATUS;
  localparam logic [15:0] MK = ch3_io_pkg::IDX_MASK;
  logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, ev = 0, fa = 0, fb = 0;
  logic [17:0] paddr = 0;
  logic [31:0] pwd = 0, prd, rd;
  logic [15:0] cnt = 0, ga, gb, v;
  logic [2:0]  presc = 0;
  logic [7:0]  rb;
  logic [3:0]  code;
  logic        prdy, perr, er, pa, pb, oa, ob, wa, wb, irq, la, lb, oe;
  logic [3:0]  cc [4] = '{4'h8, 4'h9, 4'hA, 4'hC};
  int          errors = 0, cmp_count = 0, cyc = 0;

  initial forever #2 clk = ~clk;

  timer_ch3_io_control uut (
    .CLK_IN(clk), .RESET_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(paddr), .PWDATA_IN(pwd), .PREADY_OUT(prdy), .PSLVERR_OUT(perr),
    .PRDATA_OUT(prd), .CH3_COUNTER_IN(cnt), .CH4_COUNT_EVENT_IN(ev),
    .CH4_PRESCALE_IN(presc), .CH3_PIN_A_IN(wa), .CH3_PIN_A_OUT(pa),
    .CH3_PIN_A_OE_OUT(oa), .CH3_PIN_B_IN(wb), .CH3_PIN_B_OUT(pb),
    .CH3_PIN_B_OE_OUT(ob), .IRQ_OUT(irq));
  pin_far far_a (.dut_lvl_in(pa), .dut_oe_in(oa), .far_lvl_in(fa), .pin_out(wa));
  pin_far far_b (.dut_lvl_in(pb), .dut_oe_in(ob), .far_lvl_in(fb), .pin_out(wb));

  task automatic stop_test;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test

  // hang guard, well above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      stop_test();
    end
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt

  // one apb transfer, entered and left just after a rising edge
  task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] wd);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= {idx, 2'b00}; pwd <= wd;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1);
    rd = prd;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic rdc(input logic [15:0] idx, input logic [31:0] e, input logic ee = 1'b0);
    apb(1'b0, idx, 32'h0);
    `CHK(rd, e)
    `CHK(er, ee)
  endtask : rdc

  // counter visits a value for one cycle only
  task automatic pc(input logic [15:0] x);
    cnt <= x;
    @(posedge clk);
    cnt <= 16'h0;
    wt(3);
  endtask : pc

  task automatic evp(input logic [2:0] p, input logic [15:0] x);
    presc <= p; cnt <= x; ev <= 1'b1;
    @(posedge clk);
    ev <= 1'b0;
    wt(3);
  endtask : evp

  function automatic logic act(input logic [3:0] c, input logic l);
    return (c[1:0] == 2'h1) ? 1'b0 : (c[1:0] == 2'h2) ? 1'b1 : (c[1:0] == 2'h3) ? ~l : l;
  endfunction : act

  initial begin
    void'($urandom(2592));
    wt(4);
    rst_n <= 1'b1;
    wt(3);
    // reset values, refused address, reserved bits
    rdc(PF, 32'h0);
    rdc(GA, 32'hFFFF);
    rdc(GB, 32'hFFFF);
    rdc(ST, 32'h0);
    rdc(MK, 32'h0);
    apb(1'b1, 16'h0001, 32'hFF);
    `CHK(er, 1'b1)
    rdc(16'h0001, 32'h0, 1'b1);
    rb = 8'($urandom);
    apb(1'b1, PF, {24'hFFFFFF, rb});
    rdc(PF, {24'h0, rb});
    apb(1'b1, PF, 32'h0);
    wt(8);
    apb(1'b1, ST, 32'hF);
    // compare codes on both registers, two rounds of matches each
    for (int c = 0; c < 8; c++) begin
      code = 4'(c);
      apb(1'b1, PF, {24'h0, code, code});
      wt(2);
      la = code[2];
      lb = code[2];
      oe = (code[1:0] != 2'h0);
      `CHK(oa, oe)
      `CHK(ob, oe)
      ga = 16'h0100 + 16'($urandom_range(16'h7000));
      gb = ga + 16'h1;
      apb(1'b1, GA, {16'h0, ga});
      apb(1'b1, GB, {16'h0, gb});
      for (int k = 0; k < 2; k++) begin
        pc(ga);
        la = act(code, la);
        pc(gb);
        lb = act(code, lb);
        if (oe) begin
          `CHK(pa, la)
          `CHK(pb, lb)
        end
      end
    end
    rdc(ST, 32'h3);
    apb(1'b1, MK, 32'h3);
    wt(2);
    `CHK(irq, 1'b1)
    apb(1'b1, ST, 32'h3);
    wt(2);
    `CHK(irq, 1'b0)
    // capture codes; far pins idle low before each switch
    apb(1'b1, PF, 32'h0);
    wt(8);
    foreach (cc[i]) begin
      code = cc[i];
      apb(1'b1, PF, {24'h0, code, code});
      wt(4);
      v = 16'($urandom);
      cnt <= v; fa <= 1'b1; fb <= 1'b1;
      wt(8);
      if (code == 4'h8 || code[3:1] == 3'h5) begin
        ga = v;
        gb = v;
      end
      v = 16'($urandom);
      cnt <= v; fa <= 1'b0; fb <= 1'b0;
      wt(8);
      if (code == 4'h9 || code[3:1] == 3'h5) begin
        ga = v;
        gb = v;
      end
      v = 16'($urandom);
      evp(3'(1 + $urandom_range(6)), v);
      if (code[3:2] == 2'h3) begin
        ga = v;
        gb = v;
      end
      evp(3'h0, 16'($urandom));
      rdc(GA, {16'h0, ga});
      rdc(GB, {16'h0, gb});
    end
    `CHK(irq, 1'b0)
    rdc(ST, 32'hC);
    apb(1'b1, MK, 32'hC);
    wt(2);
    `CHK(irq, 1'b1)
    apb(1'b1, ST, 32'hC);
    wt(2);
    `CHK(irq, 1'b0)
    stop_test();
  end
endmodule : timer_ch3_io_control_test
`default_nettype wire
